// ### hw/clockgen_serial_control_regs.sv
// serial control bank of the clock synthesizer: two-wire byte slave,
// control bytes 0 to 4 and the gating levels for the clock buffers
// assumes scl/sda synchronous to i_ref_clk and an external open-drain pad
//
// Operation
// - byte write: address, command, data, each acked
// - byte read: command, repeated start, one byte out
// - ack address only when seven bits match
// - capture command code and ack it
// - byte 0 enables eight differential pairs
// - byte 1 misc enables, bit 3 reads 0
// - byte 1 bit 0 switches spread on
// - byte 2 pci enables, reserved bits stored
// - byte 3 bits 7-1 stop src pairs
// - byte 3 bit 0 stops on pin only
// - 96 MHz pair floats in power-down if set
// - byte 4 bits 4-3 make free clocks stoppable
// - byte 4 bits 2-0 gate host pairs
// - command bit 7 selects byte access, offset below
// - answer only to address bytes d2 (write) and d3 (read)
// - all bytes take defaults at power-up
// - after power-good, pin becomes power-down input
`timescale 1ns/1ps
module clockgen_serial_control_regs import clkgen_pkg::*; (
    input wire logic i_ref_clk, // 250 MHz system clock
    input wire logic i_sys_rst, // sync reset, high
    input wire logic i_clk_en, // freezes state when low
    input wire logic i_scl, // serial clock from master
    input wire logic i_sda, // serial data line level
    input wire logic i_host_clock_stop_n, // host clock stop, low
    input wire logic i_bus_clock_stop_n, // bus clock stop pin, low
    input wire logic i_soft_bus_clock_stop, // software bus stop, high
    input wire logic i_power_good_strobe_n, // power-good, then power-down
    output logic o_sda_out, // sda drive value, always 0
    output logic o_sda_oe, // sda pulled low while high
    output logic [7:0] o_src_oe, // src pair output enables
    output logic [7:0] o_src_run, // src pairs not stopped
    output logic [1:0] o_host_oe, // host pair 1/0 enables
    output logic [2:0] o_host_run, // host pairs not stopped
    output logic [1:0] o_free_bus_oe, // free bus clock 1/0 enables
    output logic [1:0] o_free_bus_run, // free bus clocks not stopped
    output logic [3:0] o_pci_oe, // pci 5..2 enables
    output logic o_fixed_96mhz_oe, // 96 MHz pair driven
    output logic o_usb48_oe, // 48 MHz output enable
    output logic o_xtal_copy_oe, // crystal copy enable
    output logic o_spread_en, // spread spectrum on
    output logic o_power_down_state // power-down in force
);
    // ======================================================
    // line events and bank
    logic rise_p, fall_p, start_p, stop_p, sda_v;
    logic [7:0] rd_data, q_diff, q_misc, q_pci, q_src, q_host;
    logic wr_en;

    twi_line_sampler u_lines (
        .i_ref_clk(i_ref_clk),
        .i_sys_rst(i_sys_rst),
        .i_clk_en(i_clk_en),
        .i_scl(i_scl),
        .i_sda(i_sda),
        .o_scl_rise(rise_p),
        .o_scl_fall(fall_p),
        .o_start(start_p),
        .o_stop(stop_p),
        .o_sda(sda_v)
    );

    logic [6:0] ofs_r, ofs_nxt;
    logic [7:0] shift_r, shift_nxt;

    ctrl_byte_bank u_bank (
        .i_ref_clk(i_ref_clk),
        .i_sys_rst(i_sys_rst),
        .i_clk_en(i_clk_en),
        .i_wr_en(wr_en),
        .i_ofs(ofs_r),
        .i_wr_data(shift_r),
        .o_rd_data(rd_data),
        .o_diff_oe(q_diff),
        .o_misc(q_misc),
        .o_pci_oe(q_pci),
        .o_src_mask(q_src),
        .o_host_mask(q_host)
    );

    // ======================================================
    // serial slave state
    twi_state_e st_r, st_nxt, after_r, after_nxt;
    logic [3:0] cnt_r, cnt_nxt;
    logic byte_mode_r, byte_mode_nxt;
    logic sda_oe_nxt, byte_done;

    assign byte_done = (cnt_r == BYTE_BITS);

    // bit collection, ack slots and read shift-out
    always_comb begin
        st_nxt = st_r;
        after_nxt = after_r;
        cnt_nxt = cnt_r;
        shift_nxt = shift_r;
        ofs_nxt = ofs_r;
        byte_mode_nxt = byte_mode_r;
        sda_oe_nxt = o_sda_oe;
        wr_en = 1'b0;
        if (stop_p) begin
            st_nxt = S_IDLE;
            sda_oe_nxt = 1'b0;
        end else if (start_p) begin
            st_nxt = S_ADDR;
            cnt_nxt = 4'h0;
            sda_oe_nxt = 1'b0;
        end else begin
            case (st_r)
                S_ADDR, S_CMD, S_WDATA: begin
                    if (rise_p && !byte_done) begin
                        shift_nxt = {shift_r[6:0], sda_v};
                        cnt_nxt = cnt_r + 4'h1;
                    end else if (fall_p && byte_done) begin
                        cnt_nxt = 4'h0;
                        st_nxt = S_ACK;
                        sda_oe_nxt = 1'b1;
                        if (st_r == S_ADDR) begin
                            after_nxt = shift_r[0] ? S_RDATA : S_CMD;
                            if (shift_r[7:1] != DEV_ADDR) begin
                                st_nxt = S_IGNORE;
                                sda_oe_nxt = 1'b0;
                            end
                        end else if (st_r == S_CMD) begin
                            ofs_nxt = shift_r[6:0];
                            byte_mode_nxt = shift_r[CMD_BYTE_BIT];
                            after_nxt = S_WDATA;
                        end else begin
                            wr_en = byte_mode_r;
                            after_nxt = S_IGNORE;
                        end
                    end
                end
                S_ACK: begin
                    if (fall_p) begin
                        st_nxt = after_r;
                        cnt_nxt = 4'h0;
                        sda_oe_nxt = 1'b0;
                        if (after_r == S_RDATA) begin
                            shift_nxt = rd_data;
                            sda_oe_nxt = !rd_data[7];
                            cnt_nxt = 4'h1;
                        end
                    end
                end
                S_RDATA: begin
                    if (fall_p) begin
                        if (byte_done) begin
                            sda_oe_nxt = 1'b0;
                            st_nxt = S_MACK;
                        end else begin
                            sda_oe_nxt = !shift_r[6];
                            shift_nxt = {shift_r[6:0], 1'b0};
                            cnt_nxt = cnt_r + 4'h1;
                        end
                    end
                end
                S_MACK: begin
                    if (rise_p) begin
                        st_nxt = S_IGNORE; // single byte only
                    end
                end
                default: begin
                end
            endcase
        end
        if (!i_clk_en) begin
            wr_en = 1'b0;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            st_r <= S_IDLE;
            after_r <= S_IDLE;
            cnt_r <= 4'h0;
            shift_r <= 8'h00;
            ofs_r <= 7'h00;
            byte_mode_r <= 1'b0;
            o_sda_oe <= 1'b0;
            o_sda_out <= 1'b0;
        end else if (i_clk_en) begin
            st_r <= st_nxt;
            after_r <= after_nxt;
            cnt_r <= cnt_nxt;
            shift_r <= shift_nxt;
            ofs_r <= ofs_nxt;
            byte_mode_r <= byte_mode_nxt;
            o_sda_oe <= sda_oe_nxt;
            o_sda_out <= 1'b0;
        end
    end

    // ======================================================
    // buffer gating
    logic armed_r, armed_nxt, bus_stop, sleep_nxt;
    logic [7:0] src_run_nxt;
    logic [2:0] host_run_nxt;
    logic [1:0] free_run_nxt;

    // stop pins and software stop applied to run levels, power-down state from power-good
    always_comb begin
        bus_stop = !i_bus_clock_stop_n || i_soft_bus_clock_stop;
        armed_nxt = armed_r || !i_power_good_strobe_n;
        sleep_nxt = armed_r && i_power_good_strobe_n;
        src_run_nxt[7:1] = ~(q_src[7:1] & {7{bus_stop}});
        src_run_nxt[0] = !(q_src[0] && !i_bus_clock_stop_n);
        host_run_nxt = ~(q_host[2:0] & {3{!i_host_clock_stop_n}});
        free_run_nxt = ~(q_host[4:3] & {2{bus_stop}});
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            armed_r <= 1'b0;
            o_power_down_state <= 1'b0;
            o_src_oe <= RST_DIFF_OE;
            o_src_run <= 8'hff;
            o_host_oe <= 2'h3;
            o_host_run <= 3'h7;
            o_free_bus_oe <= 2'h3;
            o_free_bus_run <= 2'h3;
            o_pci_oe <= 4'hf;
            o_fixed_96mhz_oe <= 1'b1;
            o_usb48_oe <= 1'b1;
            o_xtal_copy_oe <= 1'b1;
            o_spread_en <= 1'b0;
        end else if (i_clk_en) begin
            armed_r <= armed_nxt;
            o_power_down_state <= sleep_nxt;
            o_src_oe <= q_diff;
            o_src_run <= src_run_nxt;
            o_host_oe <= q_misc[2:1];
            o_host_run <= host_run_nxt;
            o_free_bus_oe <= {q_pci[FREE1_OE_BIT], q_misc[FREE0_OE_BIT]};
            o_free_bus_run <= free_run_nxt;
            o_pci_oe <= q_pci[7:4];
            o_fixed_96mhz_oe <= q_misc[DOT_OE_BIT]
                && !(sleep_nxt && q_host[DOT_SLEEP_HIZ_BIT]);
            o_usb48_oe <= q_misc[USB_OE_BIT];
            o_xtal_copy_oe <= q_misc[XTAL_OE_BIT];
            o_spread_en <= q_misc[SPREAD_BIT];
        end
    end

    // ======================================================
    // checks
    default clocking cb @(posedge i_ref_clk);
    endclocking
    default disable iff (i_sys_rst);

    logic quiet;
    assign quiet = i_clk_en && !start_p && !stop_p;

    sequence addr_end;
        quiet && st_r == S_ADDR && fall_p && byte_done;
    endsequence
    sequence cmd_end;
        quiet && st_r == S_CMD && fall_p && byte_done;
    endsequence
    sequence ack_slot;
        o_sda_oe && st_r == S_ACK;
    endsequence

    addr_mismatch_a: assert property (addr_end and (shift_r[7:1] != DEV_ADDR) |=> !o_sda_oe)
        else $error("ack given to foreign address");
    addr_match_a: assert property (addr_end and (shift_r[7:1] == DEV_ADDR) |=> ack_slot)
        else $error("own address not acked");
    cmd_capture_a: assert property (cmd_end |=> ack_slot and ofs_r == $past(shift_r[6:0]))
        else $error("command not captured and acked");
    write_store_a: assert property (quiet && st_r == S_WDATA && fall_p && byte_done
        && byte_mode_r && ofs_r == OFS_DIFF_OE |=> ack_slot ##0 rd_data == $past(shift_r))
        else $error("written byte not stored");
    ack_release_a: assert property (quiet && st_r == S_ACK && fall_p && after_r != S_RDATA
        |=> !o_sda_oe)
        else $error("ack not released");
    read_first_a: assert property (quiet && st_r == S_ACK && fall_p && after_r == S_RDATA
        |=> o_sda_oe == !$past(rd_data[7]) && st_r == S_RDATA)
        else $error("read msb wrong");
    read_release_a: assert property (quiet && st_r == S_RDATA && fall_p && byte_done
        |=> !o_sda_oe && st_r == S_MACK)
        else $error("sda held after read byte");
    src_stop_a: assert property (i_clk_en && !i_bus_clock_stop_n && q_src[1]
        |=> !o_src_run[1])
        else $error("src pair 1 not stopped");
    src0_soft_a: assert property (i_clk_en && i_bus_clock_stop_n && i_soft_bus_clock_stop
        |=> o_src_run[0])
        else $error("src pair 0 stopped by software");
    host_stop_a: assert property (i_clk_en && !i_host_clock_stop_n && q_host[0]
        |=> !o_host_run[0])
        else $error("host pair 0 not stopped");
    free_stop_a: assert property (i_clk_en && bus_stop && q_host[3] |=> !o_free_bus_run[0])
        else $error("free bus clock 0 not stopped");
    spread_follow_a: assert property (i_clk_en |=> o_spread_en == $past(q_misc[SPREAD_BIT]))
        else $error("spread enable not following byte 1");
    dot_hiz_a: assert property (i_clk_en && armed_r && i_power_good_strobe_n
        && q_host[DOT_SLEEP_HIZ_BIT] |=> !o_fixed_96mhz_oe && o_power_down_state)
        else $error("96 MHz pair driven in power-down");
    sleep_unarmed_a: assert property (!armed_r |=> !o_power_down_state)
        else $error("power-down before power-good");
    reset_values_a: assert property (disable iff (1'b0) i_sys_rst |=> o_src_oe == RST_DIFF_OE
        && o_pci_oe == 4'hf && !o_spread_en && o_host_run == 3'h7)
        else $error("wrong power-up values");
endmodule // clockgen_serial_control_regs

// ### hw/clkgen_pkg.sv
// control byte map, defaults and serial state codes for the clock
// synthesizer control bank; shared by every design file under hw/
package clkgen_pkg;
    // ======================================================
    // serial addressing
    localparam logic [6:0] DEV_ADDR = 7'h69; // eight-bit form 8'hd2
    localparam logic [3:0] BYTE_BITS = 4'h8;
    localparam int CMD_BYTE_BIT = 7;
    localparam logic [6:0] NUM_BYTES = 7'h05;
    // ======================================================
    // control byte offsets
    localparam logic [6:0] OFS_DIFF_OE = 7'h00;
    localparam logic [6:0] OFS_MISC = 7'h01;
    localparam logic [6:0] OFS_PCI_OE = 7'h02;
    localparam logic [6:0] OFS_SRC_MASK = 7'h03;
    localparam logic [6:0] OFS_HOST_MASK = 7'h04;
    // ======================================================
    // power-up values and fixed bits
    localparam logic [7:0] RST_DIFF_OE = 8'hff;
    localparam logic [7:0] RST_MISC = 8'hf6;
    localparam logic [7:0] RST_PCI_OE = 8'hff;
    localparam logic [7:0] RST_SRC_MASK = 8'h00;
    localparam logic [7:0] RST_HOST_MASK = 8'h07;
    localparam logic [7:0] MISC_RSVD_MASK = 8'hf7;
    // ======================================================
    // field positions
    localparam int FREE0_OE_BIT = 7;
    localparam int DOT_OE_BIT = 6;
    localparam int USB_OE_BIT = 5;
    localparam int XTAL_OE_BIT = 4;
    localparam int SPREAD_BIT = 0;
    localparam int FREE1_OE_BIT = 0;
    localparam int DOT_SLEEP_HIZ_BIT = 6;
    // ======================================================
    // serial slave states
    typedef enum logic [2:0] {
        S_IDLE = 3'b000,
        S_ADDR = 3'b001,
        S_CMD = 3'b010,
        S_WDATA = 3'b011,
        S_ACK = 3'b100,
        S_RDATA = 3'b101,
        S_MACK = 3'b110,
        S_IGNORE = 3'b111
    } twi_state_e;
endpackage

// ### hw/twi_line_sampler.sv
// edge and condition detector for the two-wire serial lines
// assumes scl and sda already synchronous to i_ref_clk
`timescale 1ns/1ps
module twi_line_sampler import clkgen_pkg::*; (
    input wire logic i_ref_clk, // system clock
    input wire logic i_sys_rst, // sync reset, high
    input wire logic i_clk_en, // freezes state when low
    input wire logic i_scl, // serial clock level
    input wire logic i_sda, // serial data level
    output logic o_scl_rise, // scl rising pulse
    output logic o_scl_fall, // scl falling pulse
    output logic o_start, // start or repeated start
    output logic o_stop, // stop condition
    output logic o_sda // sda level at this edge
);
    logic scl_r, scl_nxt;
    logic sda_r, sda_nxt;

    // ======================================================
    // previous line levels
    always_comb begin
        scl_nxt = i_scl;
        sda_nxt = i_sda;
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            scl_r <= 1'b1;
            sda_r <= 1'b1;
        end else if (i_clk_en) begin
            scl_r <= scl_nxt;
            sda_r <= sda_nxt;
        end
    end

    // data moving while scl high marks start or stop
    assign o_scl_rise = !scl_r && i_scl;
    assign o_scl_fall = scl_r && !i_scl;
    assign o_start = scl_r && i_scl && sda_r && !i_sda;
    assign o_stop = scl_r && i_scl && !sda_r && i_sda;
    assign o_sda = i_sda;
endmodule // twi_line_sampler

// ### hw/ctrl_byte_bank.sv
// five control bytes with power-up defaults, one write and one read port
// assumes writes arrive as single-cycle strobes from the serial slave
`timescale 1ns/1ps
module ctrl_byte_bank import clkgen_pkg::*; (
    input wire logic i_ref_clk, // system clock
    input wire logic i_sys_rst, // sync reset, high
    input wire logic i_clk_en, // freezes state when low
    input wire logic i_wr_en, // write strobe
    input wire logic [6:0] i_ofs, // byte offset
    input wire logic [7:0] i_wr_data, // byte to store
    output logic [7:0] o_rd_data, // byte at offset
    output logic [7:0] o_diff_oe, // byte 0
    output logic [7:0] o_misc, // byte 1
    output logic [7:0] o_pci_oe, // byte 2
    output logic [7:0] o_src_mask, // byte 3
    output logic [7:0] o_host_mask // byte 4
);
    logic [7:0] regs_r [0:4];
    logic [7:0] regs_nxt [0:4];

    // offsets past byte 4 fall outside the map
    function automatic logic in_map(input logic [6:0] ofs);
        return ofs < NUM_BYTES;
    endfunction

    // ======================================================
    // write decode; offsets past the map are dropped
    always_comb begin
        for (int i = 0; i < 5; i++) begin
            regs_nxt[i] = regs_r[i];
        end
        if (i_wr_en && in_map(i_ofs)) begin
            regs_nxt[i_ofs[2:0]] = i_wr_data;
        end
    end

    // power-up defaults so the part runs with no serial access
    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            regs_r[0] <= RST_DIFF_OE;
            regs_r[1] <= RST_MISC;
            regs_r[2] <= RST_PCI_OE;
            regs_r[3] <= RST_SRC_MASK;
            regs_r[4] <= RST_HOST_MASK;
        end else if (i_clk_en) begin
            regs_r <= regs_nxt;
        end
    end

    // readback of stored bytes, byte 1 bit 3 fixed at zero
    always_comb begin
        o_rd_data = 8'h00;
        if (in_map(i_ofs)) begin
            o_rd_data = regs_r[i_ofs[2:0]];
        end
        if (i_ofs == OFS_MISC) begin
            o_rd_data = regs_r[1] & MISC_RSVD_MASK;
        end
    end

    assign o_diff_oe = regs_r[0];
    assign o_misc = regs_r[1] & MISC_RSVD_MASK;
    assign o_pci_oe = regs_r[2];
    assign o_src_mask = regs_r[3];
    assign o_host_mask = regs_r[4];
endmodule // ctrl_byte_bank

// ### tb/twi_master_model.sv
// two-wire bus master model: drives scl and pulls sda low
// assumes the bench resolves the pulled-up sda wire from all enables
`timescale 1ns/1ps
module twi_master_model (
    input wire logic i_ref_clk, // system clock
    input wire logic i_sda, // resolved sda level
    output logic o_scl, // serial clock, high when idle
    output logic o_sda_oe, // high pulls sda low
    output logic o_done, // one-cycle result pulse
    output logic [7:0] o_result // ack bits or read byte
);
    initial begin
        o_scl = 1'b1;
        o_sda_oe = 1'b0;
        o_done = 1'b0;
        o_result = 8'h00;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge i_ref_clk);
    endtask
    // data changes only while scl is low
    task automatic put_bit(input logic b);
        o_sda_oe <= ~b;
        tick(2);
        o_scl <= 1'b1;
        tick(4);
        o_scl <= 1'b0;
        tick(2);
    endtask
    // released line, sampled after three of the four high cycles
    task automatic get_bit(output logic b);
        o_sda_oe <= 1'b0;
        tick(2);
        o_scl <= 1'b1;
        tick(3);
        b = i_sda;
        tick(1);
        o_scl <= 1'b0;
        tick(2);
    endtask
    // start or repeated start: sda falls while scl high
    task automatic start_cond();
        o_sda_oe <= 1'b0;
        tick(2);
        o_scl <= 1'b1;
        tick(4);
        o_sda_oe <= 1'b1;
        tick(4);
        o_scl <= 1'b0;
        tick(2);
    endtask
    task automatic stop_cond();
        o_sda_oe <= 1'b1;
        tick(2);
        o_scl <= 1'b1;
        tick(4);
        o_sda_oe <= 1'b0;
        tick(4);
    endtask
    // byte msb first, then the slave ack bit (0 = acked)
    task automatic send_byte(input logic [7:0] v, output logic nak);
        for (int i = 7; i >= 0; i--) begin
            put_bit(v[i]);
        end
        get_bit(nak);
    endtask
    task automatic finish_with(input logic [7:0] r);
        stop_cond();
        o_result <= r;
        o_done <= 1'b1;
        tick(1);
        o_done <= 1'b0;
    endtask
    // address+w, command, one data byte, stop
    task automatic write_byte_cycle(input logic [7:0] adr, input logic [7:0] cmd,
                                    input logic [7:0] dat);
        logic [2:0] a;
        start_cond();
        send_byte(adr, a[2]);
        send_byte(cmd, a[1]);
        send_byte(dat, a[0]);
        finish_with({5'h00, a});
    endtask
    // command, repeated start, address+r, byte in, nack, stop
    task automatic read_byte_cycle(input logic [7:0] cmd);
        logic [2:0] a;
        logic [7:0] d;
        start_cond();
        send_byte(8'hd2, a[2]);
        send_byte(cmd, a[1]);
        start_cond();
        send_byte(8'hd3, a[0]);
        for (int i = 7; i >= 0; i--) begin
            get_bit(d[i]);
        end
        put_bit(1'b1);
        finish_with(d);
    endtask
endmodule // twi_master_model

// ### tb/test_clockgen_serial_control_regs.sv
// self-checking bench for the serial control bank
// assumes the two-wire master model and a pulled-up sda wire
`timescale 1ns/1ps
module test_clockgen_serial_control_regs import clkgen_pkg::*;;
    typedef struct {string what; logic [33:0] val;} note_s;
    localparam int LIMIT = 40000;
    logic clk = 1'b0, rst = 1'b1, clk_en = 1'b1, probe_go = 1'b0, sleep = 1'b0;
    logic host_stop_n = 1'b1, bus_stop_n = 1'b1, soft_stop = 1'b0, pgood_n = 1'b1;
    logic scl, mst_oe, mst_done, dev_out, dev_oe, fixed_oe, usb_oe, xtal_oe, spread, sleep_st;
    logic [7:0] mst_res, src_oe, src_run, b[5];
    logic [3:0] pci_oe;
    logic [2:0] host_run;
    logic [1:0] host_oe, free_oe, free_run;
    wire logic sda = (dev_oe ? dev_out : 1'b1) & ~mst_oe;
    wire logic [33:0] obs = {src_oe, src_run, host_oe, host_run, free_oe, free_run, pci_oe,
                             fixed_oe, usb_oe, xtal_oe, spread, sleep_st};
    note_s notes[$];
    int fails = 0, num_checks = 0, cycles = 0, seed;
    always #2 clk = ~clk;
    twi_master_model mst (.i_ref_clk(clk), .i_sda(sda), .o_scl(scl), .o_sda_oe(mst_oe),
                          .o_done(mst_done), .o_result(mst_res));
    clockgen_serial_control_regs uut (.i_ref_clk(clk), .i_sys_rst(rst), .i_clk_en(clk_en),
        .i_scl(scl), .i_sda(sda), .i_host_clock_stop_n(host_stop_n),
        .i_bus_clock_stop_n(bus_stop_n), .i_soft_bus_clock_stop(soft_stop),
        .i_power_good_strobe_n(pgood_n), .o_sda_out(dev_out), .o_sda_oe(dev_oe),
        .o_src_oe(src_oe), .o_src_run(src_run), .o_host_oe(host_oe), .o_host_run(host_run),
        .o_free_bus_oe(free_oe), .o_free_bus_run(free_run), .o_pci_oe(pci_oe),
        .o_fixed_96mhz_oe(fixed_oe), .o_usb48_oe(usb_oe), .o_xtal_copy_oe(xtal_oe),
        .o_spread_en(spread), .o_power_down_state(sleep_st));
    // ======================================================
    // expected gating levels from stored bytes and pins
    function automatic logic [33:0] expect_outs();
        logic bs;
        bs = !bus_stop_n | soft_stop;
        return {b[0], ~(b[3][7:1] & {7{bs}}), ~(b[3][0] & !bus_stop_n), b[1][2:1],
                ~(b[4][2:0] & {3{!host_stop_n}}), b[2][0], b[1][7], ~(b[4][4] & bs),
                ~(b[4][3] & bs), b[2][7:4], b[1][6] & ~(sleep & b[4][6]), b[1][5], b[1][4],
                b[1][0], sleep};
    endfunction
    task automatic note(input string w, input logic [33:0] v);
        note_s n;
        n.what = w;
        n.val = v;
        notes.push_back(n);
    endtask
    task automatic probe();
        mst.tick(4);
        note("outputs", expect_outs());
        probe_go <= 1'b1;
        mst.tick(1);
        probe_go <= 1'b0;
    endtask
    // reserved bits kept as software must write them
    task automatic wr(input logic [6:0] ofs, input logic [7:0] v);
        if (ofs == 7'h02) v = v | 8'h0e;
        if (ofs == 7'h04) v = v & 8'h5f;
        if (ofs < 7'h05) b[ofs] = v;
        note("acks", 34'h0);
        mst.write_byte_cycle(8'hd2, {1'b1, ofs}, v);
    endtask
    task automatic rd(input logic [6:0] ofs);
        note("byte", (ofs > 7'h04) ? 34'h0
                     : {26'h0, (ofs == 7'h01) ? b[1] & MISC_RSVD_MASK : b[ofs]});
        mst.read_byte_cycle({1'b1, ofs});
    endtask
    task automatic report_and_stop();
        if (fails == 0 && num_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // ======================================================
    // result watcher: oldest note against each result seen
    always @(posedge clk) begin : watch
        note_s cur;
        logic [33:0] got;
        if (probe_go === 1'b1 || mst_done === 1'b1) begin
            got = (probe_go === 1'b1) ? obs : {26'h0, mst_res};
            cur = notes.pop_front();
            num_checks++;
            if (got !== cur.val) begin
                $display("[FAIL] %s expected %h seen %h", cur.what, cur.val, got);
                fails++;
            end
        end
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == LIMIT) begin
            fails++;
            report_and_stop();
        end
    end
    // ======================================================
    // main sequence
    initial begin
        seed = 32'hbdfa;
        b = '{RST_DIFF_OE, RST_MISC, RST_PCI_OE, RST_SRC_MASK, RST_HOST_MASK};
        mst.tick(3);
        rst <= 1'b0;
        mst.tick(2);
        probe();
        for (int i = 0; i < 6; i++) rd(i[6:0]);
        for (int i = 0; i < 6; i++) wr(i[6:0], 8'($random(seed)));
        for (int i = 0; i < 6; i++) rd(i[6:0]);
        probe();
        for (int j = 0; j < 2; j++) begin
            wr(7'h03, j ? 8'h81 : 8'h7e);
            wr(7'h04, j ? 8'h15 : 8'h4a);
            for (int i = 0; i < 8; i++) begin
                host_stop_n <= i[0];
                bus_stop_n <= i[1];
                soft_stop <= i[2];
                probe();
            end
        end
        pgood_n <= 1'b0;
        mst.tick(3);
        pgood_n <= 1'b1;
        sleep = 1'b1;
        probe();
        wr(7'h04, 8'h4a);
        probe();
        pgood_n <= 1'b0;
        sleep = 1'b0;
        probe();
        note("acks", 34'h7);
        mst.write_byte_cycle(8'hd0, 8'h80, 8'h00);
        note("acks", 34'h0);
        mst.write_byte_cycle(8'hd2, 8'h00, 8'h00);
        rd(7'h00);
        report_and_stop();
    end
endmodule // test_clockgen_serial_control_regs
